/* File: common/cmp_pkg.sv */
// constants and types shared by the dual comparator monitor
// assumes a single 50 MHz system clock and an 8-bit register port
package cmp_pkg;
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int CHANNELS = 2;

    // register offsets
    localparam logic [9:0] OFF_CTRL = 10'h1f8;
    localparam logic [9:0] OFF_INEN = 10'h1fa;
    localparam logic [9:0] OFF_FSEL = 10'h1fc;
    localparam logic [9:0] OFF_STAT = 10'h1f0;
    localparam logic [9:0] OFF_MASK = 10'h1f1;

    // comparator_control fields
    localparam int CTRL_EN1 = 0;
    localparam int CTRL_RES1 = 3;
    localparam int CTRL_EN3 = 4;
    localparam int CTRL_RES3 = 7;

    // input_enable_control fields
    localparam int INEN_IRQ1 = 2;
    localparam int INEN_EDGE1 = 3;
    localparam int INEN_IRQ3 = 6;
    localparam int INEN_EDGE3 = 7;

    // filter_select fields, low bit of each pair
    localparam int FSEL_CH1 = 2;
    localparam int FSEL_CH3 = 6;

    // reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [1:0] RST_CH = 2'h0;
    localparam logic [4:0] RST_PRESCALE = 5'h00;

    // sampling prescaler
    localparam logic [2:0] DIV8_LAST = 3'h7;
    localparam logic [4:0] DIV32_LAST = 5'h1f;

    // consecutive equal samples the filter needs
    localparam int FILTER_SAMPLES = 3;

    typedef enum logic [1:0] {
        FILT_NONE = 2'b00,
        FILT_F1 = 2'b01,
        FILT_F8 = 2'b10,
        FILT_F32 = 2'b11
    } filt_sel_t;

    typedef struct packed {
        logic enable;
        logic irq_en;
        logic edge_both;
        filt_sel_t filt;
    } chan_cfg_t;

    typedef struct packed {
        logic f1;
        logic f8;
        logic f32;
    } ticks_t;

    // pick the sample strobe that a filter setting asks for
    function automatic logic sample_tick(input filt_sel_t sel,
                                         input ticks_t t);
        logic r;
        r = 1'b0;
        unique case (sel)
            FILT_NONE: r = 1'b0;
            FILT_F1: r = t.f1;
            FILT_F8: r = t.f8;
            FILT_F32: r = t.f32;
        endcase
        return r;
    endfunction : sample_tick
endpackage : cmp_pkg

/* File: rtl/cmp_filter.sv */
// one comparator channel: synchroniser, digital filter, result flag
// assumes the raw comparator output is asynchronous to clk_i
`timescale 1ns/1ns
module cmp_filter (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic raw_i,
    input cmp_pkg::chan_cfg_t cfg_i,
    input cmp_pkg::ticks_t ticks_i,
    output logic result_o
);
    logic sync_a;
    logic sync_b;
    logic [cmp_pkg::FILTER_SAMPLES-1:0] hist;
    logic [cmp_pkg::FILTER_SAMPLES-1:0] next_hist;
    logic next_result;
    wire sample = cmp_pkg::sample_tick(cfg_i.filt, ticks_i);
    wire all_one = &next_hist;
    wire all_zero = ~|next_hist;
    wire level = sync_b;

    // two flops before anything reads the comparator
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= raw_i;
            sync_b <= sync_a;
        end
    end

    assign next_hist = {hist[cmp_pkg::FILTER_SAMPLES-2:0], level};

    always_comb begin
        next_result = result_o;
        if (!cfg_i.enable) begin
            next_result = 1'b0;
        end else if (cfg_i.filt == cmp_pkg::FILT_NONE) begin
            next_result = level;
        end else if (sample && all_one) begin
            next_result = 1'b1;
        end else if (sample && all_zero) begin
            next_result = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hist <= '0;
            result_o <= 1'b0;
        end else begin
            if (!cfg_i.enable) begin
                hist <= '0;
            end else if (sample) begin
                hist <= next_hist;
            end
            result_o <= next_result;
        end
    end
endmodule : cmp_filter

/* File: rtl/dual_comparator_monitor.sv */
// two comparator channels: enables, result flags, filters, interrupt
// assumes the analog cores sit outside and hand in raw async outputs
`timescale 1ns/1ns
module dual_comparator_monitor (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [9:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [1:0] cmp_raw_i,
    output logic [7:0] rdata_o,
    output logic [1:0] cmp_enable_o,
    output logic irq_o
);
    // software visible state
    logic [1:0] chan_enable;
    logic [1:0] irq_enable;
    logic [1:0] edge_both;
    logic [1:0] filt1;
    logic [1:0] filt3;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    // internal state
    logic [4:0] prescale;
    logic [1:0] result;
    logic [1:0] result_prev;

    // next values
    logic [1:0] next_status;
    logic [7:0] next_rdata;

    // address decode
    wire hit_ctrl = (addr_i == cmp_pkg::OFF_CTRL);
    wire hit_inen = (addr_i == cmp_pkg::OFF_INEN);
    wire hit_fsel = (addr_i == cmp_pkg::OFF_FSEL);
    wire hit_stat = (addr_i == cmp_pkg::OFF_STAT);
    wire hit_mask = (addr_i == cmp_pkg::OFF_MASK);

    wire wr_ctrl = wr_i && hit_ctrl;
    wire wr_inen = wr_i && hit_inen;
    wire wr_fsel = wr_i && hit_fsel;
    wire wr_mask = wr_i && hit_mask;
    wire rd_stat = rd_i && hit_stat;

    // sample strobes shared by both filters
    cmp_pkg::ticks_t ticks;
    assign ticks.f1 = 1'b1;
    assign ticks.f8 = (prescale[2:0] == cmp_pkg::DIV8_LAST);
    assign ticks.f32 = (prescale == cmp_pkg::DIV32_LAST);

    // per-channel configuration bundles
    cmp_pkg::chan_cfg_t cfg [cmp_pkg::CHANNELS];
    assign cfg[0].enable = chan_enable[0];
    assign cfg[0].irq_en = irq_enable[0];
    assign cfg[0].edge_both = edge_both[0];
    assign cfg[0].filt = cmp_pkg::filt_sel_t'(filt1);
    assign cfg[1].enable = chan_enable[1];
    assign cfg[1].irq_en = irq_enable[1];
    assign cfg[1].edge_both = edge_both[1];
    assign cfg[1].filt = cmp_pkg::filt_sel_t'(filt3);

    // edge events per channel
    wire [1:0] rise = result & ~result_prev;
    wire [1:0] fall = ~result & result_prev;
    // one-edge mode requests on the rising edge only
    wire [1:0] event_hit = irq_enable & (rise | (edge_both & fall));

    genvar ch;
    generate
        for (ch = 0; ch < cmp_pkg::CHANNELS; ch++) begin : g_chan
            // each channel's core sees only its own raw comparator bit
            cmp_filter u_filter (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .raw_i(cmp_raw_i[ch]),
                .cfg_i(cfg[ch]),
                .ticks_i(ticks),
                .result_o(result[ch])
            );
        end
    endgenerate

    // set wins over the clear-on-read
    assign next_status = (irq_status & ~{2{rd_stat}}) | event_hit;

    // read mux
    // flag reads 0 from the edge the enable drops, not one cycle later
    wire [7:0] rd_ctrl_val = {
        result[1] & chan_enable[1],
        2'b00,
        chan_enable[1],
        result[0] & chan_enable[0],
        2'b00,
        chan_enable[0]
    };
    wire [7:0] rd_inen_val = {
        edge_both[1],
        irq_enable[1],
        2'b00,
        edge_both[0],
        irq_enable[0],
        2'b00
    };
    wire [7:0] rd_fsel_val = {filt3, 2'b00, filt1, 2'b00};
    wire [7:0] rd_stat_val = {6'h00, irq_status};
    wire [7:0] rd_mask_val = {6'h00, irq_mask};

    always_comb begin
        next_rdata = 8'h00;
        if (hit_ctrl) begin
            next_rdata = rd_ctrl_val;
        end else if (hit_inen) begin
            next_rdata = rd_inen_val;
        end else if (hit_fsel) begin
            next_rdata = rd_fsel_val;
        end else if (hit_stat) begin
            next_rdata = rd_stat_val;
        end else if (hit_mask) begin
            next_rdata = rd_mask_val;
        end
    end

    // channel enables
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chan_enable <= cmp_pkg::RST_CH;
        end else if (wr_ctrl) begin
            chan_enable[0] <= wdata_i[cmp_pkg::CTRL_EN1];
            chan_enable[1] <= wdata_i[cmp_pkg::CTRL_EN3];
        end
    end

    // request enable and edge select
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_enable <= cmp_pkg::RST_CH;
            edge_both <= cmp_pkg::RST_CH;
        end else if (wr_inen) begin
            irq_enable[0] <= wdata_i[cmp_pkg::INEN_IRQ1];
            edge_both[0] <= wdata_i[cmp_pkg::INEN_EDGE1];
            irq_enable[1] <= wdata_i[cmp_pkg::INEN_IRQ3];
            edge_both[1] <= wdata_i[cmp_pkg::INEN_EDGE3];
        end
    end

    // filter select per channel
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            filt1 <= cmp_pkg::RST_CH;
            filt3 <= cmp_pkg::RST_CH;
        end else if (wr_fsel) begin
            filt1 <= wdata_i[cmp_pkg::FSEL_CH1 +: 2];
            filt3 <= wdata_i[cmp_pkg::FSEL_CH3 +: 2];
        end
    end

    // mask register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_mask <= cmp_pkg::RST_CH;
        end else if (wr_mask) begin
            irq_mask <= wdata_i[1:0];
        end
    end

    // sticky status and edge history
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            irq_status <= cmp_pkg::RST_CH;
            result_prev <= cmp_pkg::RST_CH;
        end else begin
            irq_status <= next_status;
            result_prev <= result;
        end
    end

    // free-running divider; filters tolerate its phase at enable
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prescale <= cmp_pkg::RST_PRESCALE;
        end else begin
            prescale <= 5'(prescale + 5'h01);
        end
    end

    // all outputs straight from flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= cmp_pkg::RST_REG8;
            cmp_enable_o <= cmp_pkg::RST_CH;
            irq_o <= 1'b0;
        end else begin
            rdata_o <= rd_i ? next_rdata : cmp_pkg::RST_REG8;
            cmp_enable_o <= chan_enable;
            irq_o <= |(next_status & irq_mask);
        end
    end
endmodule : dual_comparator_monitor

/* File: dv/cmp_monitor_props.sv */
// port-level checks for the dual comparator monitor
// assumes the register map and timing of cmp_pkg, bound to the top
`timescale 1ns/1ns
module cmp_monitor_props (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [9:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [1:0] cmp_raw_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] cmp_enable_o,
    input wire logic irq_o
);
    wire logic rd_ctrl = rd_i && addr_i == cmp_pkg::OFF_CTRL;
    wire logic wr_ctrl = wr_i && addr_i == cmp_pkg::OFF_CTRL;
    wire logic wr_mask = wr_i && addr_i == cmp_pkg::OFF_MASK;
    wire logic mapped = addr_i inside {cmp_pkg::OFF_CTRL, cmp_pkg::OFF_INEN,
        cmp_pkg::OFF_FSEL, cmp_pkg::OFF_STAT, cmp_pkg::OFF_MASK};
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (rd_i && !mapped |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    AST_CTRL_FIELDS: assert property (rd_ctrl |=> rdata_o[2:1] == 2'h0
        && rdata_o[6:5] == 2'h0 && (!rdata_o[3] || rdata_o[0])
        && (!rdata_o[7] || rdata_o[4]))
        else $error("control read shows a bad result field");
    AST_STAT_RESV: assert property (rd_i && addr_i == cmp_pkg::OFF_STAT
        |=> rdata_o[7:2] == 6'h00)
        else $error("status read shows unused bits");
    AST_EN_FOLLOW: assert property (wr_ctrl |-> ##2
        cmp_enable_o == {$past(wdata_i[4], 2), $past(wdata_i[0], 2)})
        else $error("enable outputs do not follow the write");
    AST_EN_CAUSE: assert property ($changed(cmp_enable_o)
        |-> $past(wr_ctrl, 2))
        else $error("enable outputs changed without a write");
    AST_READBACK: assert property (wr_ctrl ##1 rd_ctrl |=>
        rdata_o[4] == $past(wdata_i[4], 2)
        && rdata_o[0] == $past(wdata_i[0], 2))
        else $error("enable bits do not read back");
    AST_MASK_OFF: assert property (wr_mask && wdata_i[1:0] == 2'h0
        ##1 !wr_mask |=> !irq_o)
        else $error("interrupt high with mask cleared");

    cover property (rd_ctrl ##1 rdata_o[3]);
    cover property ($rose(irq_o));
    cover property (rd_i && addr_i == cmp_pkg::OFF_STAT ##1 rdata_o[1]);
endmodule : cmp_monitor_props

bind dual_comparator_monitor cmp_monitor_props props_u (.clk_i(clk_i),
    .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .cmp_raw_i(cmp_raw_i), .rdata_o(rdata_o),
    .cmp_enable_o(cmp_enable_o), .irq_o(irq_o));

/* File: dv/test_dual_comparator_monitor.sv */
// self-checking bench for the dual comparator monitor
// assumes the bench drives the raw comparator outputs directly
`timescale 1ns/1ns
module test_dual_comparator_monitor;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [9:0] addr_i = 10'h000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [1:0] cmp_raw_i = 2'b00;
    logic [7:0] rdata_o;
    logic [1:0] cmp_enable_o;
    logic irq_o;
    int mismatches = 0;
    int num_checks = 0;

    dual_comparator_monitor dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .cmp_raw_i(cmp_raw_i), .rdata_o(rdata_o),
        .cmp_enable_o(cmp_enable_o), .irq_o(irq_o));

    always #10 clk_i = ~clk_i;

    task automatic results();
        if (mismatches == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // the gap edge keeps a strobe from being set twice in one step
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", rdata_o, e);
        @(posedge clk_i);
    endtask : rd

    task automatic raw(input logic [1:0] v, input int n);
        cmp_raw_i <= v;
        repeat (n) @(posedge clk_i);
    endtask : raw

    initial begin
        repeat (10) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        rd(cmp_pkg::OFF_CTRL, 8'h00);
        rd(cmp_pkg::OFF_INEN, 8'h00);
        rd(cmp_pkg::OFF_FSEL, 8'h00);
        wr(cmp_pkg::OFF_MASK, 8'h00);
        rd(cmp_pkg::OFF_MASK, 8'h00);
        rd(cmp_pkg::OFF_STAT, 8'h00);
        rd(10'h3ff, 8'h00);
        // write then read back with no gap between the strobes
        wr_i <= 1'b1;
        addr_i <= cmp_pkg::OFF_CTRL;
        wdata_i <= 8'hff;
        @(posedge clk_i);
        wr_i <= 1'b0;
        rd(cmp_pkg::OFF_CTRL, 8'h11);
        @(negedge clk_i) chk("enable", {6'h00, cmp_enable_o}, 8'h03);
        @(posedge clk_i);
        raw(2'b01, 6);
        rd(cmp_pkg::OFF_CTRL, 8'h19);
        raw(2'b11, 6);
        rd(cmp_pkg::OFF_CTRL, 8'h99);
        raw(2'b10, 6);
        rd(cmp_pkg::OFF_CTRL, 8'h91);
        raw(2'b11, 2);
        wr(cmp_pkg::OFF_CTRL, 8'h10);
        raw(2'b11, 4);
        rd(cmp_pkg::OFF_CTRL, 8'h90);
        @(negedge clk_i) chk("enable", {6'h00, cmp_enable_o}, 8'h02);
        @(posedge clk_i);
        wr(cmp_pkg::OFF_CTRL, 8'h11);
        raw(2'b00, 8);
        wr(cmp_pkg::OFF_MASK, 8'h03);
        wr(cmp_pkg::OFF_INEN, 8'h04);
        rd(cmp_pkg::OFF_STAT, 8'h00);
        raw(2'b01, 6);
        @(negedge clk_i) chk("irq", {7'h00, irq_o}, 8'h01);
        @(posedge clk_i);
        rd(cmp_pkg::OFF_STAT, 8'h01);
        @(negedge clk_i) chk("irq", {7'h00, irq_o}, 8'h00);
        @(posedge clk_i);
        rd(cmp_pkg::OFF_STAT, 8'h00);
        raw(2'b00, 6);
        rd(cmp_pkg::OFF_STAT, 8'h00);
        wr(cmp_pkg::OFF_INEN, 8'h0c);
        rd(cmp_pkg::OFF_INEN, 8'h0c);
        raw(2'b01, 6);
        rd(cmp_pkg::OFF_STAT, 8'h01);
        raw(2'b00, 6);
        rd(cmp_pkg::OFF_STAT, 8'h01);
        wr(cmp_pkg::OFF_INEN, 8'h40);
        wr(cmp_pkg::OFF_MASK, 8'h01);
        raw(2'b10, 6);
        @(negedge clk_i) chk("irq", {7'h00, irq_o}, 8'h00);
        @(posedge clk_i);
        // pending channel-three bit shows once unmasked, hides when masked
        wr(cmp_pkg::OFF_MASK, 8'h03);
        @(negedge clk_i) chk("irq", {7'h00, irq_o}, 8'h01);
        @(posedge clk_i);
        wr(cmp_pkg::OFF_MASK, 8'h00);
        @(negedge clk_i) chk("irq", {7'h00, irq_o}, 8'h00);
        @(posedge clk_i);
        rd(cmp_pkg::OFF_STAT, 8'h02);
        raw(2'b11, 6);
        rd(cmp_pkg::OFF_STAT, 8'h00);
        raw(2'b00, 8);
        // one-cycle glitch must never pass; f32 still settling at 40
        for (int m = 1; m < 4; m++) begin
            wr(cmp_pkg::OFF_FSEL, 8'(m << 2));
            rd(cmp_pkg::OFF_FSEL, 8'(m << 2));
            raw(2'b00, 120);
            raw(2'b01, 1);
            raw(2'b00, 120);
            rd(cmp_pkg::OFF_CTRL, 8'h11);
            raw(2'b01, 40);
            rd(cmp_pkg::OFF_CTRL, m == 3 ? 8'h11 : 8'h19);
            raw(2'b01, 100);
            rd(cmp_pkg::OFF_CTRL, 8'h19);
        end
        results();
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        mismatches++;
        results();
    end
endmodule : test_dual_comparator_monitor
